// >>> eam_host.sv
// Purpose: host controller model on the register word port
// Assumes: one-cycle strobes, read data valid one cycle after the strobe
// Notes:   released write data shows the inverse of the last value
`timescale 1ns/10ps
module eam_host (
	input  wire logic        clock,
	input  wire logic [23:0] reg_rdata,
	output logic [7:0]       reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [23:0]      reg_wdata
);
	// idle bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 24'h000000;
	end

	// one write strobe, data released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask

	// read strobe, answer taken once the taking edge has landed
	task automatic rd(input logic [7:0] a, output logic [23:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule // eam_host

// >>> eam_monitor.sv
// Purpose: energy buckets, min/max/peak, alarms and pin drive
// Assumes: measurement inputs come from logic on the same clock
// Notes:   register words reached by the serial front end port
`timescale 1ns/10ps
module eam_monitor
	import eam_pkg::*;
#(
	parameter logic [23:0] BKT_INT_DEF  = 24'h000001,
	parameter logic [23:0] BKT_FRAC_DEF = 24'h000000,
	parameter logic [23:0] HOLD_DEF     = 24'h000000,
	parameter logic [23:0] SEL_DEF      = 24'h000000,
	parameter logic        SPI_LEVEL    = 1'b0
)(
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire logic [7:0]         reg_addr,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [23:0]        reg_wdata,
	output logic [23:0]             reg_rdata,
	output logic [23:0]             harmonic_select,
	output logic                    nv_save_req,
	input  wire logic               accum_done,
	input  wire logic signed [47:0] e_active,
	input  wire logic signed [47:0] e_reactive,
	input  wire logic signed [47:0] e_apparent,
	input  wire logic [23:0]        sel_amp,
	input  wire logic [23:0]        total_amp,
	input  wire logic signed [23:0] vrms,
	input  wire logic signed [23:0] irms,
	input  wire logic signed [23:0] power,
	input  wire logic signed [23:0] temperature,
	input  wire logic signed [23:0] frequency,
	input  wire logic               sample_valid,
	input  wire logic signed [23:0] v_sample,
	input  wire logic signed [23:0] i_sample,
	input  wire logic               cycle_done,
	input  wire logic signed [23:0] cycle_vrms,
	input  wire logic               zero_cross,
	input  wire logic               interface_select_pin_in,
	output logic                    interface_select_pin_out,
	output logic                    interface_select_pin_oe,
	output logic                    general_pin_7_out,
	output logic                    general_pin_7_oe,
	output logic                    general_pin_5_out,
	output logic                    general_pin_5_oe
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one bucket step: {up, down, residue}
	function automatic logic [51:0] bkt(input logic signed [49:0] s, input logic signed [49:0] b);
		if (b != 0 && s >= b)
			return {2'b10, s - b};
		else if (b != 0 && s <= -b)
			return {2'b01, s + b};
		return {2'b00, s};
	endfunction
	function automatic logic [23:0] mag(input logic signed [23:0] x);
		return x[23] ? 24'(-x) : x;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [23:0]        hsel_q, bint_q, bfrac_q, hold_q, pol_q;
	logic [23:0]        alarm_q, alarm_d, fund_q, harmonic_select_q;
	logic [23:0]        vhi_q, vlo_q, ihi_q, ilo_q, vpk_q, ipk_q, vrun_q, irun_q;
	logic [23:0]        cyc_lo_q, cyc_hi_q, drop_th_q, drop_hold_q, drop_cnt_q;
	logic [23:0]        sel_q [3];
	logic [23:0]        th_q [NCOND];
	logic [23:0]        ho_q [NCOND];
	logic [23:0]        run_q [NCOND];
	logic [23:0]        run_d [NCOND];
	logic [23:0]        evc_q [NEVC];
	logic [23:0]        ecnt_q [5];
	logic signed [49:0] esum_q [5];
	logic [51:0]        step [5];
	logic signed [49:0] add_e [5];
	logic signed [49:0] bucket;
	logic [NCOND-1:0]   cond, cev, clive;
	logic [NEVC-1:0]    evinc;
	logic [23:0]        set_ev, live, force_w, clr_w, pin_act;
	logic               sag_q, surge_q, sag_c, surge_c, drop_ev, drop_live;
	logic               clr_energy, sync1_q, sync2_q, spi_q, caught_q;
	logic [2:0]         pin_out_q, pin_oe_q;
	logic [23:0]        dcnt_n;
	logic signed [23:0] mon [NCOND];

	assign bucket = {2'b00, bint_q, bfrac_q}; // 24.24 unsigned
	assign clr_energy = reg_wr && reg_addr == A_CMD && reg_wdata[23:16] == CMD_CLR_ENERGY;
	assign force_w = (reg_wr && reg_addr == A_FORCE) ? reg_wdata : 24'h000000;
	assign clr_w = (reg_wr && reg_addr == A_CLEAR) ? reg_wdata : 24'h000000;

	// ----------------------------------------
	// configuration words
	// ----------------------------------------
	// host-written words; selects, hold and bucket reload parameter defaults
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			hsel_q <= HSEL_RST;
			bint_q <= BKT_INT_DEF;
			bfrac_q <= BKT_FRAC_DEF;
			hold_q <= HOLD_DEF;
			pol_q <= 24'h000000;
			cyc_lo_q <= 24'h000000;
			cyc_hi_q <= 24'h7fffff;
			drop_th_q <= 24'h000000;
			drop_hold_q <= 24'h000000;
			for (int j = 0; j < 3; j++)
				sel_q[j] <= SEL_DEF;
			for (int k = 0; k < NCOND; k++)
			begin
				th_q[k] <= 24'h000000;
				ho_q[k] <= 24'h000000;
			end
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				A_HSEL: hsel_q <= reg_wdata;
				A_BKT_INT: bint_q <= reg_wdata;
				A_BKT_FRAC: bfrac_q <= reg_wdata;
				A_HOLD: hold_q <= reg_wdata;
				A_POL: pol_q <= reg_wdata;
				A_CYC_LO: cyc_lo_q <= reg_wdata;
				A_CYC_HI: cyc_hi_q <= reg_wdata;
				A_DROP_TH: drop_th_q <= reg_wdata;
				A_DROP_HOLD: drop_hold_q <= reg_wdata;
				default: ;
			endcase
			for (int j = 0; j < 3; j++)
				if (reg_addr == A_SEL + 8'(j))
					sel_q[j] <= reg_wdata;
			for (int k = 0; k < NCOND; k++)
			begin
				if (reg_addr == A_TH + 8'(k))
					th_q[k] <= reg_wdata;
				if (reg_addr == A_HO + 8'(k))
					ho_q[k] <= reg_wdata;
			end
		end
	end

	// save request pulse on the save command
	always_ff @(posedge clock)
		nv_save_req <= !reset && reg_wr && reg_addr == A_CMD && reg_wdata[23:8] == CMD_SAVE;

	// ----------------------------------------
	// harmonic results
	// ----------------------------------------
	// fundamental word holds the selected harmonic, harmonic word the balance
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			fund_q <= 24'h000000;
			harmonic_select_q <= 24'h000000;
		end
		else if (accum_done)
		begin
			fund_q <= sel_amp;
			harmonic_select_q <= total_amp - sel_amp;
		end
	end
	assign harmonic_select = hsel_q;

	// ----------------------------------------
	// energy buckets
	// ----------------------------------------
	// import, export, net active, net reactive, net apparent
	always_comb
	begin
		add_e[0] = e_active > 0 ? 50'(e_active) : 50'sd0;
		add_e[1] = e_active < 0 ? -50'(e_active) : 50'sd0;
		add_e[2] = 50'(e_active);
		add_e[3] = 50'(e_reactive);
		add_e[4] = 50'(e_apparent);
		for (int k = 0; k < 5; k++)
			step[k] = bkt(esum_q[k] + add_e[k], bucket);
	end

	// residue kept, counter steps per bucket, cleared by command
	always_ff @(posedge clock)
	begin
		for (int k = 0; k < 5; k++)
		begin
			if (reset || clr_energy)
			begin
				esum_q[k] <= 50'sd0;
				ecnt_q[k] <= 24'h000000;
			end
			else if (accum_done)
			begin
				esum_q[k] <= step[k][49:0];
				ecnt_q[k] <= ecnt_q[k] + 24'(step[k][51]) - 24'(step[k][50]);
			end
		end
	end

	// ----------------------------------------
	// min, max and peak
	// ----------------------------------------
	// host write restarts a tracker; write wins over tracking
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			vhi_q <= HI_RESTART;
			ihi_q <= HI_RESTART;
			vlo_q <= LO_RESTART;
			ilo_q <= LO_RESTART;
		end
		else if (reg_wr && reg_addr == A_VHI)
			vhi_q <= reg_wdata;
		else if (reg_wr && reg_addr == A_VLO)
			vlo_q <= reg_wdata;
		else if (reg_wr && reg_addr == A_IHI)
			ihi_q <= reg_wdata;
		else if (reg_wr && reg_addr == A_ILO)
			ilo_q <= reg_wdata;
		else if (accum_done)
		begin
			if (vrms > $signed(vhi_q)) vhi_q <= vrms;
			if (vrms < $signed(vlo_q)) vlo_q <= vrms;
			if (irms > $signed(ihi_q)) ihi_q <= irms;
			if (irms < $signed(ilo_q)) ilo_q <= irms;
		end
	end

	// running peak magnitude, published and restarted each interval
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			vrun_q <= 24'h000000;
			irun_q <= 24'h000000;
			vpk_q <= 24'h000000;
			ipk_q <= 24'h000000;
		end
		else if (accum_done)
		begin
			vpk_q <= vrun_q;
			ipk_q <= irun_q;
			vrun_q <= 24'h000000;
			irun_q <= 24'h000000;
		end
		else if (sample_valid)
		begin
			if (mag(v_sample) > vrun_q) vrun_q <= mag(v_sample);
			if (mag(i_sample) > irun_q) irun_q <= mag(i_sample);
		end
	end

	// ----------------------------------------
	// threshold alarms with hold-off
	// ----------------------------------------
	// max above, min below; condition counted in intervals
	always_comb
	begin
		mon = '{temperature, temperature, vrms, vrms, irms, power, frequency, frequency};
		for (int k = 0; k < NCOND; k++)
		begin
			cond[k] = COND_MAX[k] ? mon[k] > $signed(th_q[k]) : mon[k] < $signed(th_q[k]);
			run_d[k] = !cond[k] ? 24'h000000 : (&run_q[k] ? run_q[k] : run_q[k] + 24'h000001);
			cev[k] = accum_done && cond[k] && run_d[k] == (ho_q[k] == 0 ? 24'h000001 : ho_q[k]);
			clive[k] = cond[k] && run_d[k] >= (ho_q[k] == 0 ? 24'h000001 : ho_q[k]);
		end
	end

	always_ff @(posedge clock)
	begin
		for (int k = 0; k < NCOND; k++)
			if (reset)
				run_q[k] <= 24'h000000;
			else if (accum_done)
				run_q[k] <= run_d[k];
	end

	// ----------------------------------------
	// sag, surge and dropout
	// ----------------------------------------
	assign sag_c = cycle_vrms < $signed(cyc_lo_q);
	assign surge_c = cycle_vrms > $signed(cyc_hi_q);
	assign dcnt_n = (mag(v_sample) < drop_th_q) ? (&drop_cnt_q ? drop_cnt_q : drop_cnt_q + 24'h000001) : 24'h000000;
	assign drop_ev = sample_valid && dcnt_n == drop_hold_q + 24'h000001;
	assign drop_live = drop_cnt_q > drop_hold_q;

	// per-cycle rms compare dropout count of samples
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sag_q <= 1'b0;
			surge_q <= 1'b0;
			drop_cnt_q <= 24'h000000;
		end
		else
		begin
			if (cycle_done)
			begin
				sag_q <= sag_c;
				surge_q <= surge_c;
			end
			if (sample_valid)
				drop_cnt_q <= dcnt_n;
		end
	end

	// ----------------------------------------
	// alarm word
	// ----------------------------------------
	always_comb
	begin
		set_ev = 24'h000000;
		live = 24'h000000;
		for (int k = 0; k < NCOND; k++)
		begin
			set_ev[COND_BIT[k]] = cev[k];
			live[COND_BIT[k]] = clive[k];
		end
		set_ev[B_FRESH] = accum_done;
		set_ev[B_SAG] = cycle_done && sag_c;
		set_ev[B_SURGE] = cycle_done && surge_c;
		set_ev[B_DROP] = drop_ev;
		set_ev[B_ZC] = zero_cross;
		live[B_FRESH] = 1'b1;
		live[B_SAG] = sag_q;
		live[B_SURGE] = surge_q;
		live[B_DROP] = drop_live;
		// hold bits keep, others follow condition at interval end
		alarm_d = accum_done ? ((alarm_q & hold_q) | live) : alarm_q;
		// clear then set, so an event in the clearing cycle survives
		alarm_d = ((alarm_d & ~clr_w) | set_ev | force_w) & ALM_USED;
		if (sample_valid)
		begin
			alarm_d[B_CURRENT_POLARITY_FLAG] = i_sample[23];
			alarm_d[B_VOLTAGE_POLARITY_FLAG] = v_sample[23];
		end
	end

	// no host write path into the status word
	always_ff @(posedge clock)
		alarm_q <= reset ? 24'h000000 : alarm_d;

	// ----------------------------------------
	// event counters
	// ----------------------------------------
	assign evinc = {surge_c && !surge_q && cycle_done, sag_c && !sag_q && cycle_done, cev};

	// count each occurrence; zero write clears, a count in the same cycle wins
	always_ff @(posedge clock)
	begin
		for (int k = 0; k < NEVC; k++)
			if (reset)
				evc_q[k] <= 24'h000000;
			else if (evinc[k])
				evc_q[k] <= (reg_wr && reg_addr == A_EVC + 8'(k) && reg_wdata == 0) ? 24'h000001 : evc_q[k] + 24'h000001;
			else if (reg_wr && reg_addr == A_EVC + 8'(k) && reg_wdata == 0)
				evc_q[k] <= 24'h000000;
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	// strap sampled once after reset release
	always_ff @(posedge clock)
	begin
		sync1_q <= interface_select_pin_in;
		sync2_q <= sync1_q;
		if (reset)
		begin
			caught_q <= 1'b0;
			spi_q <= 1'b0;
		end
		else if (!caught_q)
		begin
			caught_q <= 1'b1;
			spi_q <= sync2_q == SPI_LEVEL;
		end
	end

	// one activity bit per pin, upper bits unused
	always_comb
	begin
		pin_act = 24'h000000;
		for (int j = 0; j < 3; j++)
			pin_act[j] = |(sel_q[j] & alarm_q);
	end

	// zero select or slave-select use leaves pin undriven polarity
	always_ff @(posedge clock)
	begin
		for (int j = 0; j < 3; j++)
			if (reset)
			begin
				pin_oe_q[j] <= 1'b0;
				pin_out_q[j] <= 1'b0;
			end
			else
			begin
				pin_oe_q[j] <= caught_q && sel_q[j] != 0 && !(j == 2 && spi_q);
				pin_out_q[j] <= pin_act[j] ^ pol_q[PIN_BIT[j]];
			end
	end
	assign interface_select_pin_out = pin_out_q[0];
	assign interface_select_pin_oe = pin_oe_q[0];
	assign general_pin_7_out = pin_out_q[1];
	assign general_pin_7_oe = pin_oe_q[1];
	assign general_pin_5_out = pin_out_q[2];
	assign general_pin_5_oe = pin_oe_q[2];

	// ----------------------------------------
	// register read
	// ----------------------------------------
	// read data one cycle after reg_rd; unmapped reads zero
	always_ff @(posedge clock)
	begin
		if (reset)
			reg_rdata <= 24'h000000;
		else if (reg_rd)
		begin
			reg_rdata <= 24'h000000;
			case (reg_addr)
				A_HSEL: reg_rdata <= hsel_q;
				A_BKT_INT: reg_rdata <= bint_q;
				A_BKT_FRAC: reg_rdata <= bfrac_q;
				A_STATUS: reg_rdata <= alarm_q;
				A_HOLD: reg_rdata <= hold_q;
				A_POL: reg_rdata <= pol_q;
				A_VHI: reg_rdata <= vhi_q;
				A_VLO: reg_rdata <= vlo_q;
				A_IHI: reg_rdata <= ihi_q;
				A_ILO: reg_rdata <= ilo_q;
				A_VPK: reg_rdata <= vpk_q;
				A_IPK: reg_rdata <= ipk_q;
				A_FUND: reg_rdata <= fund_q;
				A_HARMONIC_SELECT: reg_rdata <= harmonic_select_q;
				A_CYC_LO: reg_rdata <= cyc_lo_q;
				A_CYC_HI: reg_rdata <= cyc_hi_q;
				A_DROP_TH: reg_rdata <= drop_th_q;
				A_DROP_HOLD: reg_rdata <= drop_hold_q;
				default: ;
			endcase
			for (int k = 0; k < 5; k++)
				if (reg_addr == A_ECNT + 8'(k)) reg_rdata <= ecnt_q[k];
			for (int j = 0; j < 3; j++)
				if (reg_addr == A_SEL + 8'(j)) reg_rdata <= sel_q[j];
			for (int k = 0; k < NCOND; k++)
			begin
				if (reg_addr == A_TH + 8'(k)) reg_rdata <= th_q[k];
				if (reg_addr == A_HO + 8'(k)) reg_rdata <= ho_q[k];
			end
			for (int k = 0; k < NEVC; k++)
				if (reg_addr == A_EVC + 8'(k)) reg_rdata <= evc_q[k];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_force6;
		reg_wr && reg_addr == A_FORCE && reg_wdata[6];
	endsequence
	property p_bucket;
		accum_done && !clr_energy && bucket != 0 && esum_q[0] + add_e[0] >= bucket
		|=> ecnt_q[0] == $past(ecnt_q[0]) + 24'h000001 && esum_q[0] == $past(esum_q[0] + add_e[0] - bucket);
	endproperty
	a_bucket: assert property (p_bucket) else $error("bucket step wrong");
	property p_clr;
		clr_energy |=> ecnt_q[4] == 0 && esum_q[0] == 0;
	endproperty
	a_clr: assert property (p_clr) else $error("energy clear failed");
	property p_force;
		s_force6 |=> alarm_q[6];
	endproperty
	a_force: assert property (p_force) else $error("force ignored");
	property p_unused;
		(alarm_q & ~ALM_USED) == 0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused alarm bit set");
	property p_fresh;
		accum_done && !(reg_wr && reg_addr == A_CLEAR) |=> alarm_q[B_FRESH] ##1 alarm_q[B_FRESH] || accum_done || $past(reg_wr);
	endproperty
	a_fresh: assert property (p_fresh) else $error("fresh flag missing");
	property p_holdoff;
		accum_done && !reg_wr && ho_q[2] > 24'h000001 && run_q[2] < ho_q[2] - 24'h000001
		|=> evc_q[2] == $past(evc_q[2]);
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("early alarm");
	property p_pin;
		caught_q && sel_q[1] != 0 ##1 $stable(sel_q[1])
		|-> general_pin_7_oe && general_pin_7_out == ($past(pin_act[1]) ^ $past(pol_q[7]));
	endproperty
	a_pin: assert property (p_pin) else $error("pin 7 drive wrong");
	property p_restart;
		reg_wr && reg_addr == A_VHI && reg_wdata == HI_RESTART |=> vhi_q == HI_RESTART;
	endproperty
	a_restart: assert property (p_restart) else $error("max restart failed");
	property p_ro;
		reg_wr && reg_addr == A_STATUS && !accum_done && !cycle_done && !sample_valid && !zero_cross && !drop_ev
		|=> alarm_q == $past(alarm_q);
	endproperty
	a_ro: assert property (p_ro) else $error("status changed by write");
endmodule // eam_monitor

// >>> eam_monitor_tb.sv
// Purpose: self-checking bench of the result monitor
// Assumes: host model drives the register port
// Notes:   energy counts predicted by an integer bucket model
`timescale 1ns/10ps
module eam_monitor_tb;
	import eam_pkg::*;
	logic               clock, reset, accum_done, sample_valid, cycle_done, zero_cross;
	logic signed [47:0] e_act, e_rea;
	logic signed [23:0] vrms, vs;
	logic [23:0]        sel, tot, rdata, hsel, wdata;
	logic [7:0]         addr;
	logic               wr, rd, p7o, p7e, p5o, p5e, iso, ise, nv, strap;
	int                 bad_count, cmp_count, cycles, seed, sx;
	longint             b, en, ps, rs, pc, nr;

	eam_monitor i_eam_monitor (.clock(clock), .reset(reset), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wdata), .reg_rdata(rdata), .harmonic_select(hsel), .nv_save_req(nv), .accum_done(accum_done),
		.e_active(e_act), .e_reactive(e_rea), .e_apparent(e_act), .sel_amp(sel), .total_amp(tot), .vrms(vrms),
		.irms(24'sh000000), .power(24'sh000000), .temperature(24'sh000000), .frequency(24'sh000000),
		.sample_valid(sample_valid), .v_sample(vs), .i_sample(vs), .cycle_done(cycle_done), .cycle_vrms(vs),
		.zero_cross(zero_cross), .interface_select_pin_in(strap), .interface_select_pin_out(iso),
		.interface_select_pin_oe(ise), .general_pin_7_out(p7o), .general_pin_7_oe(p7e),
		.general_pin_5_out(p5o), .general_pin_5_oe(p5e));
	eam_host i_eam_host (.clock(clock), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wdata));

	// clock and hang guard
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			summarize();
		end
	end

	task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// read a word and compare the masked bits
	task automatic rc(input logic [7:0] a, input logic [23:0] m, input logic [23:0] e);
		logic [23:0] v;
		i_eam_host.rd(a, v);
		chk($sformatf("word %h", a), v & m, e);
	endtask
	task automatic w(input logic [7:0] a, input logic [23:0] v);
		i_eam_host.wr(a, v);
	endtask
	// one event pulse: 0 interval, 1 sample, 2 line cycle, 3 crossing
	task automatic pulse(input int k, input logic signed [23:0] v);
		@(posedge clock);
		sx = $random(seed);
		vrms <= v;
		vs <= v;
		e_act <= en[47:0];
		e_rea <= 48'(-en);
		sel <= sx[23:0];
		tot <= ~sx[23:0];
		accum_done <= (k == 0);
		sample_valid <= (k == 1);
		cycle_done <= (k == 2);
		zero_cross <= (k == 3);
		@(posedge clock);
		{accum_done, sample_valid, cycle_done, zero_cross} <= 4'h0;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		seed = 32'hb017;
		{bad_count, cmp_count, cycles} = {32'd0, 32'd0, 32'd0};
		{ps, rs, pc, nr, en} = {64'd0, 64'd0, 64'd0, 64'd0, 64'd0};
		{strap, reset, accum_done, sample_valid, cycle_done, zero_cross} = 6'h30;
		{e_act, e_rea, vrms, vs, sel, tot} = '0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		rc(A_BKT_INT, 24'hffffff, 24'h000001);
		rc(A_ECNT, 24'hffffff, 24'h000000);
		chk("harmonic_select", hsel, HSEL_RST);
		$display("test reset done");
		w(A_BKT_INT, 24'h000002);
		w(A_BKT_FRAC, 24'h800000);
		b = 64'd41943040;
		repeat (12)
		begin
			en = $random(seed) & 32'h01ffffff;
			pulse(0, 24'sh000000);
			ps += en;
			rs -= en;
			if (ps >= b)
			begin
				pc++;
				ps -= b;
			end
			if (rs <= -b)
			begin
				nr--;
				rs += b;
			end
		end
		rc(A_ECNT, 24'hffffff, pc[23:0]);
		rc(A_ECNT + 8'h01, 24'hffffff, 24'h000000);
		rc(A_ECNT + 8'h02, 24'hffffff, pc[23:0]);
		rc(A_ECNT + 8'h03, 24'hffffff, nr[23:0]);
		rc(A_ECNT + 8'h04, 24'hffffff, pc[23:0]);
		rc(A_STATUS, 24'h800000, 24'h800000);
		w(A_CMD, {CMD_CLR_ENERGY, 16'h0000});
		rc(A_ECNT + 8'h02, 24'hffffff, 24'h000000);
		w(A_CMD, {CMD_SAVE, 8'h00});
		#1 chk("save pulse", {23'h0, nv}, 24'h000001);
		en = 0;
		w(A_HSEL, 24'h000003);
		pulse(0, 24'sh000000);
		chk("harmonic_select", hsel, 24'h000003);
		rc(A_FUND, 24'hffffff, sx[23:0]);
		rc(A_HARMONIC_SELECT, 24'hffffff, ~sx[23:0] - sx[23:0]);
		$display("test energy done");
		w(A_TH + 8'h02, 24'h000064);
		w(A_HO + 8'h02, 24'h000003);
		for (int k = 1; k <= 3; k++)
		begin
			pulse(0, 24'sh0000c8);
			rc(A_STATUS, 24'h000100, (k == 3) ? 24'h000100 : 24'h000000);
			rc(A_EVC + 8'h02, 24'hffffff, (k == 3) ? 24'h000001 : 24'h000000);
		end
		rc(A_VHI, 24'hffffff, 24'h0000c8);
		pulse(0, 24'sh000000);
		rc(A_STATUS, 24'h000100, 24'h000000);
		w(A_EVC + 8'h02, 24'h000000);
		rc(A_EVC + 8'h02, 24'hffffff, 24'h000000);
		w(A_VHI, HI_RESTART);
		rc(A_VHI, 24'hffffff, 24'h000000);
		$display("test holdoff done");
		w(A_FORCE, 24'hffffff);
		rc(A_STATUS, 24'hffffff, ALM_USED);
		rc(A_FORCE, 24'hffffff, 24'h000000);
		w(A_STATUS, 24'h000000);
		rc(A_STATUS, 24'hffffff, ALM_USED);
		w(A_CLEAR, 24'hffffff);
		rc(A_STATUS, 24'hffffff, 24'h000000);
		w(A_SEL, 24'h000440);
		w(A_SEL + 8'h01, 24'h000440);
		w(A_SEL + 8'h02, 24'h000440);
		w(A_FORCE, 24'h000040);
		repeat (2) @(posedge clock);
		#1 chk("pin drive", {18'h0, p5o, iso, ise, p5e, p7e, p7o}, 24'h00003f);
		w(A_POL, 24'h000080);
		repeat (2) @(posedge clock);
		#1 chk("pin7 low", {22'h0, p7e, p7o}, 24'h000002);
		w(A_SEL + 8'h01, 24'h000000);
		repeat (2) @(posedge clock);
		#1 chk("pin7 free", {23'h0, p7e}, 24'h000000);
		w(A_CLEAR, 24'hffffff);
		$display("test alarm words done");
		w(A_CYC_LO, 24'h000064);
		pulse(2, 24'sh000032);
		rc(A_STATUS, 24'h000800, 24'h000800);
		rc(A_EVC + 8'h08, 24'hffffff, 24'h000001);
		w(A_DROP_TH, 24'h000064);
		w(A_DROP_HOLD, 24'h000003);
		for (int k = 1; k <= 4; k++)
		begin
			pulse(1, 24'sh00000a);
			rc(A_STATUS, 24'h003200, (k == 4) ? 24'h000200 : 24'h000000);
		end
		pulse(1, -24'sd5);
		pulse(3, -24'sd5);
		rc(A_STATUS, 24'h003002, 24'h003002);
		en = b;
		pulse(0, 24'sh000000);
		rc(A_VPK, 24'hffffff, 24'h00000a);
		rc(A_IPK, 24'hffffff, 24'h00000a);
		rc(A_ECNT, 24'hffffff, 24'h000001);
		$display("test line events done");
		strap <= 1'b0;
		repeat (4) @(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rc(A_ECNT, 24'hffffff, 24'h000000);
		w(A_SEL + 8'h02, 24'h000440);
		w(A_FORCE, 24'h000040);
		repeat (2) @(posedge clock);
		#1 chk("pin5 in spi", {23'h0, p5e}, 24'h000000);
		$display("test second reset done");
		summarize();
	end
endmodule // eam_monitor_tb

// >>> eam_pkg.sv
// Purpose: constants of the energy / alarm result monitor
// Assumes: 24-bit register words on the serial word port
// Notes:   word index is the register address
//
// Contract
// - fundamental words carry the selected harmonic
// - interval energy summed, counter steps per bucket
// - energy counters are 24-bit read-only results
// - import, export, net active, reactive, apparent
// - counters clear on reset or command
// - bucket is 24.24 unsigned fixed point
// - min/max rms tracking, restart by write
// - per-interval peak words refreshed each interval
// - max alarms above, min alarms below threshold
// - condition must persist hold-off intervals
// - event counters count, zero write clears
// - per-cycle rms against sag and surge thresholds
// - dropout after threshold held beyond sample count
// - bits 23,22,21 fresh/temp; 13,12 polarity
// - bits 11..7 sag, surge, dropout, voltage
// - bits 6,5 current/power, 4,3 freq, 1 crossing
// - alarm status word ignores host writes
// - hold bits stick, others follow condition next interval
// - clear and force words act then read zero
// - pin active when select AND alarms nonzero
// - interface pin sampled at reset, pin5 select
// - bucket, hold, selects storable and reloaded
// - zero select leaves pin undriven
// - polarity one drives active low
package eam_pkg;
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_HSEL = 8'h01;
	localparam logic [7:0] A_BKT_INT = 8'h02;
	localparam logic [7:0] A_BKT_FRAC = 8'h03;
	localparam logic [7:0] A_ECNT = 8'h04;   // five counters 04..08
	localparam logic [7:0] A_STATUS = 8'h09;
	localparam logic [7:0] A_HOLD = 8'h0a;
	localparam logic [7:0] A_FORCE = 8'h0b;
	localparam logic [7:0] A_CLEAR = 8'h0c;
	localparam logic [7:0] A_SEL = 8'h0d;    // pin8, pin7, pin5 selects
	localparam logic [7:0] A_POL = 8'h10;
	localparam logic [7:0] A_VHI = 8'h11;
	localparam logic [7:0] A_VLO = 8'h12;
	localparam logic [7:0] A_IHI = 8'h13;
	localparam logic [7:0] A_ILO = 8'h14;
	localparam logic [7:0] A_VPK = 8'h15;
	localparam logic [7:0] A_IPK = 8'h16;
	localparam logic [7:0] A_FUND = 8'h17;
	localparam logic [7:0] A_HARMONIC_SELECT = 8'h18;
	localparam logic [7:0] A_CYC_LO = 8'h19;
	localparam logic [7:0] A_CYC_HI = 8'h1a;
	localparam logic [7:0] A_DROP_TH = 8'h1b;
	localparam logic [7:0] A_DROP_HOLD = 8'h1c;
	localparam logic [7:0] A_TH = 8'h20;     // eight thresholds
	localparam logic [7:0] A_HO = 8'h28;     // eight hold-offs
	localparam logic [7:0] A_EVC = 8'h30;    // ten event counters
	localparam logic [7:0] CMD_CLR_ENERGY = 8'hec;
	localparam logic [15:0] CMD_SAVE = 16'hacc2;
	localparam logic [23:0] HSEL_RST = 24'h000001;
	localparam logic [23:0] HI_RESTART = 24'h000000;
	localparam logic [23:0] LO_RESTART = 24'h7fffff;
	localparam logic [23:0] ALM_USED = 24'he03ffa;
	localparam int B_FRESH = 23;
	localparam int B_CURRENT_POLARITY_FLAG = 13;
	localparam int B_VOLTAGE_POLARITY_FLAG = 12;
	localparam int B_SAG = 11;
	localparam int B_SURGE = 10;
	localparam int B_DROP = 9;
	localparam int B_ZC = 1;
	localparam int NCOND = 8;
	localparam int NEVC = 10;
	localparam int COND_BIT [NCOND] = '{22, 21, 8, 7, 6, 5, 4, 3};
	localparam logic [NCOND-1:0] COND_MAX = 8'b0111_0101;
	localparam int PIN_BIT [3] = '{8, 7, 5};
endpackage
